// ---- rtl/gtp_params.svh ----
// register map, field positions and reset values of the timer pair
`ifndef GTP_PARAMS_SVH
`define GTP_PARAMS_SVH
// register indices; the byte address on the bus is four times the index
`define GTP_IDX_AUX_CTRL 16'hff46
`define GTP_IDX_CORE_CTRL 16'hff48
`define GTP_IDX_CORE_CNT 16'hff4a
`define GTP_IDX_AUX_CNT 16'hff4c
`define GTP_IDX_CAPTURE 16'hff4e
`define GTP_RST_CTRL 16'h0000
`define GTP_RST_CNT 16'h0000
`define GTP_CNT_MAX 16'hffff
`define GTP_CNT_ZERO 16'h0000
`define GTP_CNT_ONE 16'h0001
// shared control field positions
`define GTP_B_CAP_EN 15
`define GTP_B_CLR 14
`define GTP_F_CAP_TRIG 13:12
`define GTP_F_BPS 12:11
`define GTP_B_CORR 11
`define GTP_B_TRIG_SRC 10
`define GTP_B_REMOTE 9
`define GTP_B_DIR_EN 8
`define GTP_B_DIR 7
`define GTP_B_RUN 6
`define GTP_F_MODE 5:3
`define GTP_F_ISEL 2:0
// block prescaler divide ratios, minus one
`define GTP_BPS_DIV4 4'h3
`define GTP_BPS_DIV2 4'h1
`define GTP_BPS_DIV16 4'hf
`define GTP_BPS_DIV8 4'h7
// synchroniser input lanes
`define GTP_IN_CORE_EXT 0
`define GTP_IN_CORE_DIR 1
`define GTP_IN_AUX_EXT 2
`define GTP_IN_AUX_DIR 3
`define GTP_IN_CAP_PIN 4
`define GTP_IN_REM_CNT 5
`define GTP_IN_REM_DIR 6
`define GTP_IN_N 7
`endif

// ---- rtl/gtp_pkg.sv ----
// types shared by the timer pair
package gtp_pkg;
  typedef enum logic [2:0] {
    GTP_MODE_TIMER = 3'h0,
    GTP_MODE_COUNTER = 3'h1,
    GTP_MODE_GATE_LOW = 3'h2,
    GTP_MODE_GATE_HIGH = 3'h3
  } gtp_mode_t;
  typedef enum logic [1:0] {
    GTP_BPS_4 = 2'h0,
    GTP_BPS_2 = 2'h1,
    GTP_BPS_16 = 2'h2,
    GTP_BPS_8 = 2'h3
  } gtp_bps_t;
endpackage

// ---- rtl/gtp_timer_pair.sv ----
// core and auxiliary 16-bit timers with capture register, wishbone slave
// ---------------------------------------------------------------------
// Functional notes
// - mode 000 counts prescaled module clock
// - modes 010/011 gated, bit 3 picks level
// - 010 counts on gate low, 011 high
// - gated core needs run bit and gate
// - gate edges raise no interrupt
// - mode 001 counts selected count-input edges
// - input select 0/rise/fall/both, 1xx reserved
// - aux modes timer/counter/gated, 1xx reserved
// - aux count readable and software loadable
// - bit 9 picks aux run source
// - remote run starts both timers together
// - selected run bit gates aux counting
// - bit 15 enables capture into register
// - bit 14 clears aux on capture
// - bits 13:12 select capture trigger edges
// - bit 11 stores count minus one
// - bit 10 picks capture pin or remote
// - bit 7 direction, bit 8 input enable
// - aux has no toggle latch, no pin
// - common fields share bit positions
// - aux input select prescales or picks edge
// - direction is input xor direction bit
// - block prescaler 4/2/16/8
// - core run bit starts and stops core
// ---------------------------------------------------------------------
`timescale 1ns/1ps
`include "gtp_params.svh"

module gtp_timer_pair
  import gtp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [1:0] sel_i,
  input wire logic [15:0] dat_i,
  output logic [15:0] dat_o,
  output logic ack_o,
  input wire logic core_ext_input_i,
  input wire logic core_dir_input_i,
  input wire logic aux_ext_input_i,
  input wire logic aux_dir_input_i,
  input wire logic capture_input_pin_i,
  input wire logic remote_count_input_i,
  input wire logic remote_dir_input_i,
  output logic core_wrap_o,
  output logic aux_wrap_o,
  output logic capture_o
);

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] din,
                                        input logic [1:0] be);
    merge = {be[1] ? din[15:8] : old[15:8], be[0] ? din[7:0] : old[7:0]};
  endfunction

  // count-input edge decode, 1xx counts nothing
  function automatic logic edge_hit(input logic [2:0] isel,
                                    input logic rise, input logic fall);
    edge_hit = !isel[2] && ((isel[0] && rise) || (isel[1] && fall));
  endfunction

  // prescaled tick: divide base ticks by two to the input select
  function automatic logic pre_hit(input logic [2:0] isel,
                                   input logic [6:0] cnt);
    logic [6:0] mask;
    mask = 7'((8'h01 << isel) - 8'h01);
    pre_hit = (cnt & mask) == mask;
  endfunction

  // gated/timer/counter advance decision
  function automatic logic step_ok(input logic [2:0] mode,
                                   input logic [2:0] isel, input logic run,
                                   input logic gate, input logic tick,
                                   input logic rise, input logic fall);
    logic go;
    go = 1'b0;
    unique case (mode)
      GTP_MODE_TIMER: go = tick;
      GTP_MODE_COUNTER: go = edge_hit(isel, rise, fall);
      GTP_MODE_GATE_LOW: go = tick && !gate;
      GTP_MODE_GATE_HIGH: go = tick && gate;
      default: go = 1'b0;
    endcase
    step_ok = run && go;
  endfunction

  logic [15:0] core_ctrl_reg, aux_ctrl_reg;
  logic [15:0] core_cnt_reg, aux_cnt_reg, cap_reg;
  logic ack_reg, core_wrap_reg, aux_wrap_reg, cap_pulse_reg;
  logic [15:0] rdat_reg;

  // ---------------------------------------------------------------------
  // input synchronisers and edge detection
  // ---------------------------------------------------------------------
  logic [`GTP_IN_N-1:0] raw_in, sync1_reg, sync2_reg, prev_reg;
  logic [`GTP_IN_N-1:0] rise, fall;
  assign raw_in = {remote_dir_input_i, remote_count_input_i,
                   capture_input_pin_i, aux_dir_input_i, aux_ext_input_i,
                   core_dir_input_i, core_ext_input_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `GTP_IN_N; g++) begin : g_edge
      assign rise[g] = sync2_reg[g] && !prev_reg[g];
      assign fall[g] = !sync2_reg[g] && prev_reg[g];
    end
  endgenerate

  // ---------------------------------------------------------------------
  // prescalers
  // ---------------------------------------------------------------------
  logic [3:0] bps_cnt_reg, bps_limit;
  logic [6:0] pre_cnt_reg;
  logic base_tick;

  always_comb begin
    unique case (gtp_bps_t'(core_ctrl_reg[`GTP_F_BPS]))
      GTP_BPS_4: bps_limit = `GTP_BPS_DIV4;
      GTP_BPS_2: bps_limit = `GTP_BPS_DIV2;
      GTP_BPS_16: bps_limit = `GTP_BPS_DIV16;
      GTP_BPS_8: bps_limit = `GTP_BPS_DIV8;
    endcase
  end
  assign base_tick = bps_cnt_reg >= bps_limit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bps_cnt_reg <= '0;
      pre_cnt_reg <= '0;
    end else begin
      bps_cnt_reg <= base_tick ? 4'h0 : bps_cnt_reg + 4'h1;
      if (base_tick)
        pre_cnt_reg <= pre_cnt_reg + 7'h01;
    end
  end

  // ---------------------------------------------------------------------
  // count decisions
  // ---------------------------------------------------------------------
  logic core_run, aux_run, core_step, aux_step, core_down, aux_down;
  logic core_tick, aux_tick;
  assign core_run = core_ctrl_reg[`GTP_B_RUN];
  assign aux_run = aux_ctrl_reg[`GTP_B_REMOTE] ? core_run
                                               : aux_ctrl_reg[`GTP_B_RUN];
  assign core_tick = base_tick && pre_hit(core_ctrl_reg[`GTP_F_ISEL],
                                          pre_cnt_reg);
  assign aux_tick = base_tick && pre_hit(aux_ctrl_reg[`GTP_F_ISEL],
                                         pre_cnt_reg);
  // gate edges feed only the counter, never an event output
  assign core_step = step_ok(core_ctrl_reg[`GTP_F_MODE],
    core_ctrl_reg[`GTP_F_ISEL], core_run, sync2_reg[`GTP_IN_CORE_EXT],
    core_tick, rise[`GTP_IN_CORE_EXT], fall[`GTP_IN_CORE_EXT]);
  assign aux_step = step_ok(aux_ctrl_reg[`GTP_F_MODE],
    aux_ctrl_reg[`GTP_F_ISEL], aux_run, sync2_reg[`GTP_IN_AUX_EXT],
    aux_tick, rise[`GTP_IN_AUX_EXT], fall[`GTP_IN_AUX_EXT]);
  assign core_down = core_ctrl_reg[`GTP_B_DIR] ^ (core_ctrl_reg[`GTP_B_DIR_EN]
                     && sync2_reg[`GTP_IN_CORE_DIR]);
  assign aux_down = aux_ctrl_reg[`GTP_B_DIR] ^ (aux_ctrl_reg[`GTP_B_DIR_EN]
                    && sync2_reg[`GTP_IN_AUX_DIR]);

  // ---------------------------------------------------------------------
  // capture trigger
  // ---------------------------------------------------------------------
  logic [1:0] trig_sel;
  logic cap_event;
  assign trig_sel = aux_ctrl_reg[`GTP_F_CAP_TRIG];
  always_comb begin
    if (aux_ctrl_reg[`GTP_B_TRIG_SRC])
      cap_event = (trig_sel[0] && (rise[`GTP_IN_REM_CNT]
                   || fall[`GTP_IN_REM_CNT]))
               || (trig_sel[1] && (rise[`GTP_IN_REM_DIR]
                   || fall[`GTP_IN_REM_DIR]));
    else
      cap_event = (trig_sel[0] && rise[`GTP_IN_CAP_PIN])
               || (trig_sel[1] && fall[`GTP_IN_CAP_PIN]);
  end

  // ---------------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------------
  logic req, wr_now;
  logic [15:0] idx;
  assign req = cyc_i && stb_i;
  assign idx = adr_i[17:2];
  // writes land on the edge that sees ack high, as the master expects
  assign wr_now = req && we_i && ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= req && !ack_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= '0;
    end else if (req && !ack_reg) begin
      unique case (idx)
        `GTP_IDX_AUX_CTRL: rdat_reg <= aux_ctrl_reg;
        `GTP_IDX_CORE_CTRL: rdat_reg <= core_ctrl_reg;
        `GTP_IDX_CORE_CNT: rdat_reg <= core_cnt_reg;
        `GTP_IDX_AUX_CNT: rdat_reg <= aux_cnt_reg;
        `GTP_IDX_CAPTURE: rdat_reg <= cap_reg;
        default: rdat_reg <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_ctrl_reg <= `GTP_RST_CTRL;
      aux_ctrl_reg <= `GTP_RST_CTRL;
    end else if (wr_now) begin
      if (idx == `GTP_IDX_CORE_CTRL)
        core_ctrl_reg <= merge(core_ctrl_reg, dat_i, sel_i);
      if (idx == `GTP_IDX_AUX_CTRL)
        aux_ctrl_reg <= merge(aux_ctrl_reg, dat_i, sel_i);
    end
  end

  // ---------------------------------------------------------------------
  // counters; software load beats clear, clear beats counting
  // ---------------------------------------------------------------------
  logic core_wr, aux_wr, aux_clr;
  assign core_wr = wr_now && idx == `GTP_IDX_CORE_CNT;
  assign aux_wr = wr_now && idx == `GTP_IDX_AUX_CNT;
  assign aux_clr = cap_event && aux_ctrl_reg[`GTP_B_CLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_cnt_reg <= `GTP_RST_CNT;
      core_wrap_reg <= 1'b0;
    end else begin
      core_wrap_reg <= 1'b0;
      if (core_wr) begin
        core_cnt_reg <= merge(core_cnt_reg, dat_i, sel_i);
      end else if (core_step) begin
        core_cnt_reg <= core_down ? core_cnt_reg - `GTP_CNT_ONE
                                  : core_cnt_reg + `GTP_CNT_ONE;
        core_wrap_reg <= core_down ? core_cnt_reg == `GTP_CNT_ZERO
                                   : core_cnt_reg == `GTP_CNT_MAX;
      end
    end
  end

  // no toggle latch and no pin driven from the aux count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_cnt_reg <= `GTP_RST_CNT;
      aux_wrap_reg <= 1'b0;
    end else begin
      aux_wrap_reg <= 1'b0;
      if (aux_wr) begin
        aux_cnt_reg <= merge(aux_cnt_reg, dat_i, sel_i);
      end else if (aux_clr) begin
        aux_cnt_reg <= `GTP_CNT_ZERO;
      end else if (aux_step) begin
        aux_cnt_reg <= aux_down ? aux_cnt_reg - `GTP_CNT_ONE
                                : aux_cnt_reg + `GTP_CNT_ONE;
        aux_wrap_reg <= aux_down ? aux_cnt_reg == `GTP_CNT_ZERO
                                 : aux_cnt_reg == `GTP_CNT_MAX;
      end
    end
  end

  // the capture register has no bus write path: it only reloads on capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_reg <= `GTP_RST_CNT;
      cap_pulse_reg <= 1'b0;
    end else begin
      cap_pulse_reg <= cap_event && aux_ctrl_reg[`GTP_B_CAP_EN];
      if (cap_event && aux_ctrl_reg[`GTP_B_CAP_EN])
        cap_reg <= aux_ctrl_reg[`GTP_B_CORR] ? aux_cnt_reg - `GTP_CNT_ONE
                                             : aux_cnt_reg;
    end
  end

  assign dat_o = rdat_reg;
  assign ack_o = ack_reg;
  assign core_wrap_o = core_wrap_reg;
  assign aux_wrap_o = aux_wrap_reg;
  assign capture_o = cap_pulse_reg;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bus_ack_once_a: assert property (req && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle answer");
  core_run_stop_a: assert property (!core_run && !core_wr
    |=> $stable(core_cnt_reg)) else $error("core moved while stopped");
  gate_low_hold_a: assert property (
    core_ctrl_reg[`GTP_F_MODE] == GTP_MODE_GATE_LOW
    && sync2_reg[`GTP_IN_CORE_EXT] && !core_wr |=> $stable(core_cnt_reg))
    else $error("core counted with gate inactive");
  gate_high_hold_a: assert property (
    core_ctrl_reg[`GTP_F_MODE] == GTP_MODE_GATE_HIGH
    && !sync2_reg[`GTP_IN_CORE_EXT] && !core_wr |=> $stable(core_cnt_reg))
    else $error("core counted with high gate inactive");
  count_off_a: assert property (
    core_ctrl_reg[`GTP_F_MODE] == GTP_MODE_COUNTER
    && core_ctrl_reg[`GTP_F_ISEL] == 3'h0 && !core_wr
    |=> $stable(core_cnt_reg)) else $error("disabled counter moved");
  remote_run_a: assert property (
    aux_ctrl_reg[`GTP_B_REMOTE] && !core_run && !aux_wr && !aux_clr
    |=> $stable(aux_cnt_reg)) else $error("aux ran without core run bit");
  own_run_a: assert property (
    !aux_ctrl_reg[`GTP_B_REMOTE] && !aux_ctrl_reg[`GTP_B_RUN] && !aux_wr
    && !aux_clr |=> $stable(aux_cnt_reg))
    else $error("aux ran without its run bit");
  capture_corr_a: assert property (
    cap_event && aux_ctrl_reg[`GTP_B_CAP_EN] && aux_ctrl_reg[`GTP_B_CORR]
    |=> capture_o && cap_reg == $past(aux_cnt_reg) - `GTP_CNT_ONE)
    else $error("corrected capture value wrong");
  capture_plain_a: assert property (
    cap_event && aux_ctrl_reg[`GTP_B_CAP_EN] && !aux_ctrl_reg[`GTP_B_CORR]
    |=> capture_o && cap_reg == $past(aux_cnt_reg))
    else $error("plain capture value wrong");
  capture_off_a: assert property (
    !(cap_event && aux_ctrl_reg[`GTP_B_CAP_EN]) |=> !capture_o)
    else $error("capture pulse without enabled trigger");
  clear_cap_a: assert property (aux_clr && !aux_wr
    |=> aux_cnt_reg == `GTP_CNT_ZERO) else $error("aux not cleared");
  core_wrap_a: assert property (
    core_step && !core_wr && !core_down && core_cnt_reg == `GTP_CNT_MAX
    |=> core_wrap_o && core_cnt_reg == `GTP_CNT_ZERO)
    else $error("core wrap missing");
  aux_wrap_a: assert property (
    aux_step && !aux_wr && !aux_clr && aux_down
    && aux_cnt_reg == `GTP_CNT_ZERO
    |=> aux_wrap_o && aux_cnt_reg == `GTP_CNT_MAX)
    else $error("aux underflow wrap missing");
  aux_up_a: assert property (
    aux_step && !aux_wr && !aux_clr && !aux_down
    |=> aux_cnt_reg == $past(aux_cnt_reg) + `GTP_CNT_ONE)
    else $error("aux did not count up");
  prescale_a: assert property (
    core_ctrl_reg[`GTP_F_MODE] == GTP_MODE_TIMER
    && core_run && core_ctrl_reg[`GTP_F_BPS] == GTP_BPS_2
    && core_ctrl_reg[`GTP_F_ISEL] == 3'h0 && !core_wr && !$past(core_wr)
    ##1 core_step |=> !core_step) else $error("div2 ticked twice");

  cov_capture_c: cover property (capture_o);
  cov_core_wrap_c: cover property (core_wrap_o);
  cov_aux_wrap_c: cover property (aux_wrap_o);
  cov_remote_c: cover property (aux_ctrl_reg[`GTP_B_REMOTE] && aux_step);

endmodule

// ---- sim/gtp_far_side.sv ----
// far-side model: gate, count, direction and capture line sources
`timescale 1ns/1ps
`include "gtp_params.svh"

module gtp_far_side #(
  parameter int HOLD = 8
) (
  input wire logic clk_i,
  output logic [`GTP_IN_N-1:0] lines_o
);
  // ---------------------------------------------------------------
  // line drivers
  // ---------------------------------------------------------------
  initial begin
    lines_o = '0;
  end

  // each level is held past the slowest prescaler tick in use, so the
  // synchronised edge detector never misses a transition
  task automatic toggle(input int lane);
    @(posedge clk_i);
    lines_o[lane] <= ~lines_o[lane];
    repeat (HOLD) @(posedge clk_i);
  endtask

  task automatic pulse(input int lane, input int n);
    repeat (n) begin
      toggle(lane);
      toggle(lane);
    end
  endtask
endmodule

// ---- sim/gtp_timer_pair_tb.sv ----
// self-checking bench for the timer pair over its wishbone port
`timescale 1ns/1ps
`include "gtp_params.svh"

module gtp_timer_pair_tb;
  typedef struct {logic [15:0] v; string n;} gtp_exp_t;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [17:0] adr_i;
  logic [1:0] sel_i;
  logic [15:0] dat_i, dat_o;
  logic core_wrap_o, aux_wrap_o, capture_o;
  logic [`GTP_IN_N-1:0] lines;
  gtp_exp_t exp_q[$];
  gtp_exp_t e;
  int mismatches = 0;
  int n_tests = 0;
  int n_core_wrap = 0;
  int n_aux_wrap = 0;
  int n_cap = 0;
  logic [31:0] r;

  gtp_far_side far (.clk_i(clk_i), .lines_o(lines));

  gtp_timer_pair dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o),
    .core_ext_input_i(lines[`GTP_IN_CORE_EXT]),
    .core_dir_input_i(lines[`GTP_IN_CORE_DIR]),
    .aux_ext_input_i(lines[`GTP_IN_AUX_EXT]),
    .aux_dir_input_i(lines[`GTP_IN_AUX_DIR]),
    .capture_input_pin_i(lines[`GTP_IN_CAP_PIN]),
    .remote_count_input_i(lines[`GTP_IN_REM_CNT]),
    .remote_dir_input_i(lines[`GTP_IN_REM_DIR]),
    .core_wrap_o(core_wrap_o), .aux_wrap_o(aux_wrap_o),
    .capture_o(capture_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // read data is judged at the edge where ack is sampled high
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("spare read", 16'h0001, 16'h0000);
      end else begin
        e = exp_q.pop_front();
        chk(e.n, dat_o, e.v);
      end
    end
    n_core_wrap += (core_wrap_o === 1'b1);
    n_aux_wrap += (aux_wrap_o === 1'b1);
    n_cap += (capture_o === 1'b1);
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic wb(input logic w, input logic [15:0] idx,
                    input logic [15:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 2'b11;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      chk("ack", 16'h0000, 16'h0001);
      finish_test();
    end
  endtask

  task automatic rd(input logic [15:0] idx, input logic [15:0] v,
                    input string n);
    gtp_exp_t x;
    x.v = v;
    x.n = n;
    exp_q.push_back(x);
    wb(1'b0, idx, 16'h0000);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    void'($urandom(8862));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`GTP_IDX_AUX_CTRL, `GTP_RST_CTRL, "aux ctrl reset");
    rd(`GTP_IDX_CORE_CTRL, `GTP_RST_CTRL, "core ctrl reset");
    rd(`GTP_IDX_CORE_CNT, `GTP_RST_CNT, "core count reset");
    rd(`GTP_IDX_AUX_CNT, `GTP_RST_CNT, "aux count reset");
    rd(`GTP_IDX_CAPTURE, `GTP_RST_CNT, "capture reset");
    // random control word; both run sources and the reserved mode half
    // kept off, so the aux count cannot move or wrap behind our back
    r = $urandom;
    wb(1'b1, `GTP_IDX_AUX_CTRL, r[15:0] & 16'hfd9f);
    rd(`GTP_IDX_AUX_CTRL, r[15:0] & 16'hfd9f, "aux ctrl rw");
    rd(16'hff50, 16'h0000, "unmapped read");
    wb(1'b1, `GTP_IDX_CAPTURE, 16'h5a5a);
    rd(`GTP_IDX_CAPTURE, 16'h0000, "capture read only");
    // core counter: rising edges wrap through zero
    wb(1'b1, `GTP_IDX_CORE_CNT, 16'hfffe);
    wb(1'b1, `GTP_IDX_CORE_CTRL, 16'h0049);
    far.pulse(`GTP_IN_CORE_EXT, 3);
    rd(`GTP_IDX_CORE_CNT, 16'h0001, "core rise count");
    // both edges, direction input high xor direction bit high is up
    far.toggle(`GTP_IN_CORE_DIR);
    wb(1'b1, `GTP_IDX_CORE_CTRL, 16'h01cb);
    far.pulse(`GTP_IN_CORE_EXT, 2);
    rd(`GTP_IDX_CORE_CNT, 16'h0005, "core both edges");
    wb(1'b1, `GTP_IDX_CORE_CTRL, 16'h0048);
    far.pulse(`GTP_IN_CORE_EXT, 2);
    rd(`GTP_IDX_CORE_CNT, 16'h0005, "core counting off");
    // aux counter on falling edges, run taken from the core run bit
    wb(1'b1, `GTP_IDX_AUX_CNT, 16'h1000);
    rd(`GTP_IDX_AUX_CNT, 16'h1000, "aux count load");
    wb(1'b1, `GTP_IDX_AUX_CTRL, 16'h020a);
    far.pulse(`GTP_IN_AUX_EXT, 3);
    rd(`GTP_IDX_AUX_CNT, 16'h1003, "aux remote run");
    wb(1'b1, `GTP_IDX_CORE_CTRL, 16'h0008);
    far.pulse(`GTP_IN_AUX_EXT, 2);
    rd(`GTP_IDX_AUX_CNT, 16'h1003, "aux remote stop");
    // capture on pin rise with correction, then remote edge with clear
    wb(1'b1, `GTP_IDX_AUX_CTRL, 16'h9800);
    far.pulse(`GTP_IN_CAP_PIN, 1);
    rd(`GTP_IDX_CAPTURE, 16'h1002, "capture corrected");
    rd(`GTP_IDX_AUX_CNT, 16'h1003, "aux kept");
    wb(1'b1, `GTP_IDX_AUX_CTRL, 16'hf400);
    far.toggle(`GTP_IN_REM_DIR);
    rd(`GTP_IDX_CAPTURE, 16'h1003, "capture remote");
    rd(`GTP_IDX_AUX_CNT, 16'h0000, "aux cleared");
    // gated core: inactive gate or cleared run bit holds the count
    wb(1'b1, `GTP_IDX_CORE_CNT, 16'h0000);
    far.toggle(`GTP_IN_CORE_EXT);
    wb(1'b1, `GTP_IDX_CORE_CTRL, 16'h0050);
    repeat (40) @(posedge clk_i);
    rd(`GTP_IDX_CORE_CNT, 16'h0000, "gate low idle");
    wb(1'b1, `GTP_IDX_CORE_CTRL, 16'h0018);
    repeat (40) @(posedge clk_i);
    rd(`GTP_IDX_CORE_CNT, 16'h0000, "gated run off");
    far.toggle(`GTP_IN_CORE_EXT);
    wb(1'b1, `GTP_IDX_CORE_CTRL, 16'h0058);
    repeat (40) @(posedge clk_i);
    rd(`GTP_IDX_CORE_CNT, 16'h0000, "gate high idle");
    // run writes land forty edges apart: div 2 gives exactly 20 ticks
    wb(1'b1, `GTP_IDX_CORE_CTRL, 16'h0840);
    repeat (37) @(posedge clk_i);
    wb(1'b1, `GTP_IDX_CORE_CTRL, 16'h0800);
    rd(`GTP_IDX_CORE_CNT, 16'h0014, "core timer div2");
    wb(1'b1, `GTP_IDX_CORE_CTRL, 16'h0850);
    repeat (37) @(posedge clk_i);
    wb(1'b1, `GTP_IDX_CORE_CTRL, 16'h0810);
    rd(`GTP_IDX_CORE_CNT, 16'h0028, "gate low active");
    // aux counts down through zero, then up at one tick per four edges
    wb(1'b1, `GTP_IDX_AUX_CTRL, 16'h00ca);
    far.pulse(`GTP_IN_AUX_EXT, 1);
    rd(`GTP_IDX_AUX_CNT, 16'hffff, "aux down wrap");
    wb(1'b1, `GTP_IDX_AUX_CTRL, 16'h0041);
    repeat (37) @(posedge clk_i);
    wb(1'b1, `GTP_IDX_AUX_CTRL, 16'h0001);
    rd(`GTP_IDX_AUX_CNT, 16'h0009, "aux timer prescale");
    repeat (4) @(posedge clk_i);
    chk("core wraps", 16'(n_core_wrap), 16'h0001);
    chk("aux wraps", 16'(n_aux_wrap), 16'h0002);
    chk("captures", 16'(n_cap), 16'h0002);
    chk("pending reads", 16'(exp_q.size()), 16'h0000);
    finish_test();
  end
endmodule
